// file: uart_regs_pkg.sv
/*
 Constants shared by the banked register map of a single-channel UART:
 register offsets, field positions, writable masks, reset values, timing.
 Assumes an 8-bit register space of sixteen offsets reached by the host port.
*/
`default_nettype none
package uart_regs_pkg;

    // General set offsets
    localparam logic [3:0] OFS_HOLD  = 4'h0;
    localparam logic [3:0] OFS_IER   = 4'h1;
    localparam logic [3:0] OFS_FCR   = 4'h2;
    localparam logic [3:0] OFS_LCR   = 4'h3;
    localparam logic [3:0] OFS_MCR   = 4'h4;
    localparam logic [3:0] OFS_LSR   = 4'h5;
    localparam logic [3:0] OFS_MSR   = 4'h6;
    localparam logic [3:0] OFS_SPR   = 4'h7;
    localparam logic [3:0] OFS_TX_FIFO_FILL = 4'h8;
    localparam logic [3:0] OFS_RX_FIFO_FILL = 4'h9;
    localparam logic [3:0] OFS_RSVD  = 4'hd;
    localparam logic [3:0] OFS_SRST  = 4'he;
    localparam logic [3:0] OFS_EXTRA_FEATURES  = 4'hf;
    // Divisor and enhanced sets, then the flow-control window offsets
    localparam logic [3:0] OFS_DLL   = 4'h0;
    localparam logic [3:0] OFS_DLH   = 4'h1;
    localparam logic [3:0] OFS_EFR   = 4'h2;
    localparam logic [3:0] OFS_RESUME_CHAR_ONE  = 4'h4;
    localparam logic [3:0] OFS_RESUME_CHAR_TWO  = 4'h5;
    localparam logic [3:0] OFS_PAUSE_CHAR_ONE = 4'h6;
    localparam logic [3:0] OFS_PAUSE_CHAR_TWO = 4'h7;
    localparam logic [3:0] OFS_TCR   = 4'h6;
    localparam logic [3:0] OFS_TLR   = 4'h7;

    // Field positions
    localparam int LCR_DIV_BIT   = 7;
    localparam int EFR_ENH_BIT   = 4;
    localparam int MCR_WIN_BIT   = 2;
    localparam int FCR_TXRST_BIT = 2;
    localparam int FCR_RXRST_BIT = 1;
    localparam int FCR_EN_BIT    = 0;
    localparam int SRST_BIT      = 3;

    // Line control value that opens the enhanced set
    localparam logic [7:0] LCR_ENH_KEY = 8'hbf;

    // Bits writable without the enhanced unlock, and fifo control bits writable with it
    localparam logic [7:0] IER_BASE_MASK = 8'h0f;
    localparam logic [7:0] MCR_BASE_MASK = 8'h1b;
    localparam logic [7:0] FCR_BASE_MASK = 8'hc1;
    localparam logic [7:0] FCR_ENH_MASK  = 8'hf1;
    localparam logic [7:0] ALL_MASK      = 8'hff;

    // Values after reset
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] LCR_RST = 8'h00;

    // Fifo reset is held for two sys_clk cycles
    localparam logic [1:0] FIFO_RST_CYCLES = 2'h2;

    typedef enum logic [2:0] {
        BANK_GEN = 3'b001,
        BANK_DIV = 3'b010,
        BANK_ENH = 3'b100
    } bank_t;

endpackage
`default_nettype wire

// file: cfg_reg.sv
/*
 One 8-bit configuration register with a per-bit write mask.
 Assumes the write strobe is a one-cycle pulse on sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module cfg_reg #(
    parameter int         WIDTH = 8,
    parameter logic [7:0] RESET = 8'h00
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             wrEn,
    input  wire logic [WIDTH-1:0] wrMask,
    input  wire logic [WIDTH-1:0] wrData,
    output logic      [WIDTH-1:0] q_ff
);
    // Masked bits keep their old value so locked fields survive a write
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q_ff <= RESET[WIDTH-1:0];
        end else if (wrEn) begin
            q_ff <= (wrData & wrMask) | (q_ff & ~wrMask);
        end
    end
endmodule
`default_nettype wire

// file: uart_regmap.sv
/*
 Banked register map of a single-channel UART: general, divisor and
 enhanced sets, the flow-control window and the enhanced-only bit locks.
 Assumes a host-port front end on sys_clk that issues one-cycle read and
 write strobes with a 4-bit offset, and a datapath that supplies status.
*/
// Functional notes
// - general set offsets other than line control are decoded only while line control bit 7 is clear.
// - bit 7 set and not 0xBF maps offsets 0 and 1 to divisor bytes.
// - line control 0xBF maps enhanced features, resume and pause characters.
// - offsets 6 and 7 reach window registers only with both enables set.
// - enhanced-only bits of three registers ignore writes until unlocked.
// - fifo control holds triggers and enable; its two reset bits only pulse.
// - enhanced features holds auto flow bits, detect, unlock, flow mode.
// - both divisor bytes zero stops the baud clock.
`timescale 1ns/10ps
`default_nettype none
module uart_regmap
    import uart_regs_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [3:0] regAddr,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    input  wire logic [7:0] regWrData,
    output logic      [7:0] regRdData_ff,
    output logic            regRdValid_ff,
    input  wire logic [7:0] rxHolding,
    input  wire logic [5:0] irqIdent,
    input  wire logic [7:0] lineStatus,
    input  wire logic [7:0] modemStatus,
    input  wire logic [7:0] txFifoFill,
    input  wire logic [7:0] rxFifoFill,
    output logic            rxPop_ff,
    output logic            txPush_ff,
    output logic      [7:0] txData_ff,
    output logic            irqIdentRead_ff,
    output logic            txFifoReset_ff,
    output logic            rxFifoReset_ff,
    output logic            softReset_ff,
    output logic            baudEnable_ff,
    output logic      [7:0] irqEnable_ff,
    output logic      [7:0] fifoControl_ff,
    output logic      [7:0] lineControl_ff,
    output logic      [7:0] modemControl_ff,
    output logic      [7:0] scratchpad_ff,
    output logic      [7:0] transmissionControl_ff,
    output logic      [7:0] triggerLevel_ff,
    output logic      [7:0] baudDivisorLow_ff,
    output logic      [7:0] baudDivisorHigh_ff,
    output logic      [7:0] enhancedFeatures_ff,
    output logic      [7:0] resumeCharOne_ff,
    output logic      [7:0] resumeCharTwo_ff,
    output logic      [7:0] pauseCharOne_ff,
    output logic      [7:0] pauseCharTwo_ff,
    output logic      [7:0] extraFeatures_ff
);
    bank_t      bank;
    logic       enhUnlocked;
    logic       windowOpen;
    logic       wIer, wFcr, wLcr, wMcr, wSpr, wTcr, wTlr, wDll, wDlh;
    logic       wEfr, wXon1, wXon2, wXoff1, wXoff2, wEfcr, wTxHold, wSrst;
    logic       rRxHold, rIrqId;
    logic [7:0] nxt_rdData;
    logic [7:0] ierMask, mcrMask, fcrMask;
    logic [1:0] txRstCnt_ff, rxRstCnt_ff;

    assign enhUnlocked = enhancedFeatures_ff[EFR_ENH_BIT];
    assign windowOpen  = modemControl_ff[MCR_WIN_BIT] & enhUnlocked;

    always_comb begin
        if (lineControl_ff == LCR_ENH_KEY) begin
            bank = BANK_ENH;
        end else if (lineControl_ff[LCR_DIV_BIT]) begin
            bank = BANK_DIV;
        end else begin
            bank = BANK_GEN;
        end
    end

    // Locked bits are simply left out of the mask
    always_comb begin
        ierMask = enhUnlocked ? ALL_MASK : IER_BASE_MASK;
        mcrMask = enhUnlocked ? ALL_MASK : MCR_BASE_MASK;
        fcrMask = enhUnlocked ? FCR_ENH_MASK : FCR_BASE_MASK;
    end

    // Write decode; read-only offsets have no enable at all
    always_comb begin
        wIer    = 1'b0;
        wFcr    = 1'b0;
        wMcr    = 1'b0;
        wSpr    = 1'b0;
        wTcr    = 1'b0;
        wTlr    = 1'b0;
        wDll    = 1'b0;
        wDlh    = 1'b0;
        wEfr    = 1'b0;
        wXon1   = 1'b0;
        wXon2   = 1'b0;
        wXoff1  = 1'b0;
        wXoff2  = 1'b0;
        wEfcr   = 1'b0;
        wTxHold = 1'b0;
        wSrst   = 1'b0;
        // Line control stays reachable in every bank, else no way back out
        wLcr    = regWrite && (regAddr == OFS_LCR);
        if (regWrite) begin
            case (bank)
                BANK_GEN: begin
                    wTxHold = (regAddr == OFS_HOLD);
                    wIer    = (regAddr == OFS_IER);
                    wFcr    = (regAddr == OFS_FCR);
                    wMcr    = (regAddr == OFS_MCR);
                    wTcr    = (regAddr == OFS_TCR) && windowOpen;
                    wTlr    = (regAddr == OFS_TLR) && windowOpen;
                    wSpr    = (regAddr == OFS_SPR) && !windowOpen;
                    wSrst   = (regAddr == OFS_SRST);
                    wEfcr   = (regAddr == OFS_EXTRA_FEATURES);
                end
                BANK_DIV: begin
                    wDll = (regAddr == OFS_DLL);
                    wDlh = (regAddr == OFS_DLH);
                end
                BANK_ENH: begin
                    wEfr   = (regAddr == OFS_EFR);
                    wXon1  = (regAddr == OFS_RESUME_CHAR_ONE);
                    wXon2  = (regAddr == OFS_RESUME_CHAR_TWO);
                    wXoff1 = (regAddr == OFS_PAUSE_CHAR_ONE);
                    wXoff2 = (regAddr == OFS_PAUSE_CHAR_TWO);
                end
                default: begin
                    wTxHold = 1'b0;
                end
            endcase
        end
    end

    // Read decode; unmapped offsets read as zero
    always_comb begin
        nxt_rdData = 8'h00;
        rRxHold    = 1'b0;
        rIrqId     = 1'b0;
        case (bank)
            BANK_GEN: begin
                case (regAddr)
                    OFS_HOLD: begin
                        nxt_rdData = rxHolding;
                        rRxHold    = regRead;
                    end
                    OFS_IER: nxt_rdData = irqEnable_ff;
                    OFS_FCR: begin
                        nxt_rdData = {{2{fifoControl_ff[FCR_EN_BIT]}}, irqIdent};
                        rIrqId     = regRead;
                    end
                    OFS_LCR:   nxt_rdData = lineControl_ff;
                    OFS_MCR:   nxt_rdData = modemControl_ff;
                    OFS_LSR:   nxt_rdData = lineStatus;
                    OFS_MSR:   nxt_rdData = windowOpen ? transmissionControl_ff : modemStatus;
                    OFS_SPR:   nxt_rdData = windowOpen ? triggerLevel_ff : scratchpad_ff;
                    OFS_TX_FIFO_FILL: nxt_rdData = txFifoFill;
                    OFS_RX_FIFO_FILL: nxt_rdData = rxFifoFill;
                    OFS_EXTRA_FEATURES:  nxt_rdData = extraFeatures_ff;
                    default:   nxt_rdData = 8'h00;
                endcase
            end
            BANK_DIV: begin
                case (regAddr)
                    OFS_DLL: nxt_rdData = baudDivisorLow_ff;
                    OFS_DLH: nxt_rdData = baudDivisorHigh_ff;
                    OFS_LCR: nxt_rdData = lineControl_ff;
                    default: nxt_rdData = 8'h00;
                endcase
            end
            BANK_ENH: begin
                case (regAddr)
                    OFS_EFR:   nxt_rdData = enhancedFeatures_ff;
                    OFS_LCR:   nxt_rdData = lineControl_ff;
                    OFS_RESUME_CHAR_ONE:  nxt_rdData = resumeCharOne_ff;
                    OFS_RESUME_CHAR_TWO:  nxt_rdData = resumeCharTwo_ff;
                    OFS_PAUSE_CHAR_ONE: nxt_rdData = pauseCharOne_ff;
                    OFS_PAUSE_CHAR_TWO: nxt_rdData = pauseCharTwo_ff;
                    default:   nxt_rdData = 8'h00;
                endcase
            end
            default: nxt_rdData = 8'h00;
        endcase
    end

    cfg_reg #(.WIDTH(8), .RESET(REG_RST)) ierReg (.sys_clk(sys_clk), .rst(rst), .wrEn(wIer),
        .wrMask(ierMask), .wrData(regWrData), .q_ff(irqEnable_ff));
    // Reset bits are pulses, never stored
    cfg_reg #(.WIDTH(8), .RESET(REG_RST)) fcrReg (.sys_clk(sys_clk), .rst(rst), .wrEn(wFcr),
        .wrMask(fcrMask), .wrData(regWrData), .q_ff(fifoControl_ff));
    cfg_reg #(.WIDTH(8), .RESET(LCR_RST)) lcrReg (.sys_clk(sys_clk), .rst(rst), .wrEn(wLcr),
        .wrMask(ALL_MASK), .wrData(regWrData), .q_ff(lineControl_ff));
    cfg_reg #(.WIDTH(8), .RESET(REG_RST)) mcrReg (.sys_clk(sys_clk), .rst(rst), .wrEn(wMcr),
        .wrMask(mcrMask), .wrData(regWrData), .q_ff(modemControl_ff));
    cfg_reg #(.WIDTH(8), .RESET(REG_RST)) sprReg (.sys_clk(sys_clk), .rst(rst), .wrEn(wSpr),
        .wrMask(ALL_MASK), .wrData(regWrData), .q_ff(scratchpad_ff));
    cfg_reg #(.WIDTH(8), .RESET(REG_RST)) tcrReg (.sys_clk(sys_clk), .rst(rst), .wrEn(wTcr),
        .wrMask(ALL_MASK), .wrData(regWrData), .q_ff(transmissionControl_ff));
    cfg_reg #(.WIDTH(8), .RESET(REG_RST)) tlrReg (.sys_clk(sys_clk), .rst(rst), .wrEn(wTlr),
        .wrMask(ALL_MASK), .wrData(regWrData), .q_ff(triggerLevel_ff));
    cfg_reg #(.WIDTH(8), .RESET(REG_RST)) dllReg (.sys_clk(sys_clk), .rst(rst), .wrEn(wDll),
        .wrMask(ALL_MASK), .wrData(regWrData), .q_ff(baudDivisorLow_ff));
    cfg_reg #(.WIDTH(8), .RESET(REG_RST)) dlhReg (.sys_clk(sys_clk), .rst(rst), .wrEn(wDlh),
        .wrMask(ALL_MASK), .wrData(regWrData), .q_ff(baudDivisorHigh_ff));
    cfg_reg #(.WIDTH(8), .RESET(REG_RST)) efrReg (.sys_clk(sys_clk), .rst(rst), .wrEn(wEfr),
        .wrMask(ALL_MASK), .wrData(regWrData), .q_ff(enhancedFeatures_ff));
    cfg_reg #(.WIDTH(8), .RESET(REG_RST)) xon1Reg (.sys_clk(sys_clk), .rst(rst), .wrEn(wXon1),
        .wrMask(ALL_MASK), .wrData(regWrData), .q_ff(resumeCharOne_ff));
    cfg_reg #(.WIDTH(8), .RESET(REG_RST)) xon2Reg (.sys_clk(sys_clk), .rst(rst), .wrEn(wXon2),
        .wrMask(ALL_MASK), .wrData(regWrData), .q_ff(resumeCharTwo_ff));
    cfg_reg #(.WIDTH(8), .RESET(REG_RST)) xoff1Reg (.sys_clk(sys_clk), .rst(rst), .wrEn(wXoff1),
        .wrMask(ALL_MASK), .wrData(regWrData), .q_ff(pauseCharOne_ff));
    cfg_reg #(.WIDTH(8), .RESET(REG_RST)) xoff2Reg (.sys_clk(sys_clk), .rst(rst), .wrEn(wXoff2),
        .wrMask(ALL_MASK), .wrData(regWrData), .q_ff(pauseCharTwo_ff));
    cfg_reg #(.WIDTH(8), .RESET(REG_RST)) efcrReg (.sys_clk(sys_clk), .rst(rst), .wrEn(wEfcr),
        .wrMask(ALL_MASK), .wrData(regWrData), .q_ff(extraFeatures_ff));

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            regRdData_ff    <= 8'h00;
            regRdValid_ff   <= 1'b0;
            rxPop_ff        <= 1'b0;
            irqIdentRead_ff <= 1'b0;
        end else begin
            regRdValid_ff   <= regRead;
            rxPop_ff        <= rRxHold;
            irqIdentRead_ff <= rIrqId;
            if (regRead) begin
                regRdData_ff <= nxt_rdData;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            txPush_ff <= 1'b0;
            txData_ff <= 8'h00;
        end else begin
            txPush_ff <= wTxHold;
            if (wTxHold) begin
                txData_ff <= regWrData;
            end
        end
    end

    // Fifo resets are held two cycles so the datapath clears reliably
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            txRstCnt_ff    <= 2'h0;
            rxRstCnt_ff    <= 2'h0;
            txFifoReset_ff <= 1'b0;
            rxFifoReset_ff <= 1'b0;
        end else begin
            if (wFcr && regWrData[FCR_TXRST_BIT]) begin
                txRstCnt_ff    <= FIFO_RST_CYCLES;
                txFifoReset_ff <= 1'b1;
            end else begin
                txRstCnt_ff    <= (txRstCnt_ff != 2'h0) ? txRstCnt_ff - 2'h1 : 2'h0;
                txFifoReset_ff <= (txRstCnt_ff > 2'h1);
            end
            if (wFcr && regWrData[FCR_RXRST_BIT]) begin
                rxRstCnt_ff    <= FIFO_RST_CYCLES;
                rxFifoReset_ff <= 1'b1;
            end else begin
                rxRstCnt_ff    <= (rxRstCnt_ff != 2'h0) ? rxRstCnt_ff - 2'h1 : 2'h0;
                rxFifoReset_ff <= (rxRstCnt_ff > 2'h1);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            softReset_ff  <= 1'b0;
            baudEnable_ff <= 1'b0;
        end else begin
            softReset_ff  <= wSrst && regWrData[SRST_BIT];
            baudEnable_ff <= ({baudDivisorHigh_ff, baudDivisorLow_ff} != 16'h0000);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence enterEnhanced;
        regWrite && regAddr == OFS_LCR && regWrData == LCR_ENH_KEY;
    endsequence
    sequence writeEfr;
        regWrite && regAddr == OFS_EFR;
    endsequence

    chk_gen_bank_gate: assert property (
        regWrite && regAddr == OFS_IER && lineControl_ff[LCR_DIV_BIT] |=> $stable(irqEnable_ff))
        else $error("interrupt enable changed while divisor bank selected");
    chk_div_low_write: assert property (
        regWrite && regAddr == OFS_DLL && bank == BANK_DIV
        |=> baudDivisorLow_ff == $past(regWrData) && !txPush_ff)
        else $error("divisor low byte not written in divisor bank");
    chk_enh_efr_write: assert property (
        enterEnhanced ##1 !regWrite ##1 writeEfr |=> enhancedFeatures_ff == $past(regWrData))
        else $error("enhanced features not written after key");
    chk_window_gate: assert property (
        regWrite && regAddr == OFS_TCR && bank == BANK_GEN
        |=> $past(windowOpen) ? transmissionControl_ff == $past(regWrData)
                              : $stable(transmissionControl_ff))
        else $error("transmission control written with window closed");
    chk_enh_bits_lock: assert property (
        regWrite && regAddr == OFS_MCR && bank == BANK_GEN && !enhUnlocked
        |=> modemControl_ff[7:5] == $past(modemControl_ff[7:5])
            && modemControl_ff[2] == $past(modemControl_ff[2]))
        else $error("locked modem control bits changed");
    chk_fifo_rst_len: assert property (
        regWrite && regAddr == OFS_FCR && bank == BANK_GEN && regWrData[FCR_RXRST_BIT]
        |=> rxFifoReset_ff [*2] ##1 (!rxFifoReset_ff || $past(wFcr)))
        else $error("receive fifo reset not held two cycles");
    chk_efr_unlock: assert property (
        enterEnhanced ##1 !regWrite ##1 (writeEfr and regWrData[EFR_ENH_BIT])
        |=> enhUnlocked ##0 irqEnable_ff == $past(irqEnable_ff))
        else $error("unlock bit not captured");
    chk_baud_gate: assert property (
        baudDivisorLow_ff == 8'h00 && baudDivisorHigh_ff == 8'h00 |=> !baudEnable_ff)
        else $error("baud enabled with zero divisor");
    chk_ro_write: assert property (
        regWrite && bank == BANK_GEN && (regAddr == OFS_LSR || regAddr == OFS_TX_FIFO_FILL || regAddr == OFS_RX_FIFO_FILL)
        |=> $stable(scratchpad_ff) && $stable(irqEnable_ff) && $stable(modemControl_ff)
            && $stable(resumeCharTwo_ff) && !txPush_ff)
        else $error("write to read-only offset changed state");
endmodule
`default_nettype wire

// file: uart_host_model.sv
/*
 Host model for the UART register map: issues one-cycle write and read
 strobes and notes each expected read result in expQ.
 Assumes the bench calls wr and rd from one process on sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module uart_host_model
    import uart_regs_pkg::*;
(
    input  wire logic       sys_clk,
    output logic      [3:0] regAddr,
    output logic            regWrite,
    output logic            regRead,
    output logic      [7:0] regWrData
);
    logic [7:0] expQ[$];
    logic [7:0] line_control = 8'h00;
    int         cyc = 0;
    int         rstCyc = -100;

    initial begin
        regAddr = 4'h0;
        regWrite = 1'b0;
        regRead = 1'b0;
        regWrData = 8'h00;
    end
    always @(posedge sys_clk) cyc <= cyc + 1;

    // Holding-register access waits out a fifo reset; one spare cycle covers edge races
    task automatic fifoSettle(input logic [3:0] a);
        if (a == OFS_HOLD && !line_control[7]) while (cyc < rstCyc + 3) @(posedge sys_clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (!line_control[7]) begin
            case (a)
                OFS_MCR: v = d & 8'hf6;
                OFS_FCR: v = d & 8'hf7;
                OFS_SRST: v = d & 8'h08;
                OFS_EXTRA_FEATURES: v = d & 8'hb7;
                default: v = d;
            endcase
        end
        fifoSettle(a);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= v;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
        if (a == OFS_FCR && !line_control[7] && v[2:1] != 2'b00) rstCyc = cyc;
        if (a == OFS_LCR) line_control = v;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        fifoSettle(a);
        expQ.push_back(exp);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: test_uart_regmap.sv
/*
 Self-checking bench for uart_regmap driven through uart_host_model.
 Assumes one 200 MHz clock and the one-cycle read latency of the map.
*/
`timescale 1ns/10ps
`default_nettype none
module test_uart_regmap;
    import uart_regs_pkg::*;
    logic       sys_clk = 1'b0;
    logic       rst = 1'b1;
    logic [3:0] regAddr;
    logic       regWrite, regRead, regRdValid_ff, rxPop_ff, txPush_ff, irqIdentRead_ff;
    logic       txFifoReset_ff, rxFifoReset_ff, softReset_ff, baudEnable_ff;
    logic [5:0] irqIdent;
    logic [7:0] regWrData, regRdData_ff, rxHolding, lineStatus, modemStatus, txFifoFill, rxFifoFill;
    logic [7:0] txData_ff, irqEnable_ff, fifoControl_ff, lineControl_ff, modemControl_ff, scratchpad_ff;
    logic [7:0] transmissionControl_ff, triggerLevel_ff, baudDivisorLow_ff, baudDivisorHigh_ff;
    logic [7:0] enhancedFeatures_ff, resumeCharOne_ff, resumeCharTwo_ff, pauseCharOne_ff, pauseCharTwo_ff;
    logic [7:0] extraFeatures_ff, s, e;
    int         err_count = 0;
    int         num_checks = 0;

    always #2.5 sys_clk = ~sys_clk;

    uart_host_model u_uart_host_model (.sys_clk, .regAddr, .regWrite, .regRead, .regWrData);
    uart_regmap u_uart_regmap (.sys_clk, .rst, .regAddr, .regWrite, .regRead, .regWrData, .regRdData_ff,
        .regRdValid_ff, .rxHolding, .irqIdent, .lineStatus, .modemStatus, .txFifoFill, .rxFifoFill,
        .rxPop_ff, .txPush_ff, .txData_ff, .irqIdentRead_ff, .txFifoReset_ff, .rxFifoReset_ff,
        .softReset_ff, .baudEnable_ff, .irqEnable_ff, .fifoControl_ff, .lineControl_ff, .modemControl_ff,
        .scratchpad_ff, .transmissionControl_ff, .triggerLevel_ff, .baudDivisorLow_ff, .baudDivisorHigh_ff,
        .enhancedFeatures_ff, .resumeCharOne_ff, .resumeCharTwo_ff, .pauseCharOne_ff, .pauseCharTwo_ff,
        .extraFeatures_ff);

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic wrReg(input logic [3:0] a, input logic [7:0] d);
        u_uart_host_model.wr(a, d);
    endtask
    task automatic rdReg(input logic [3:0] a, input logic [7:0] d);
        u_uart_host_model.rd(a, d);
    endtask
    task automatic close_out();
        if (err_count == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Oldest noted read result is matched against each returned read
    always @(posedge sys_clk) begin
        if (regRdValid_ff === 1'b1) begin
            if (u_uart_host_model.expQ.size() == 0) check("spare read", 8'h00, 8'hff);
            else check("read data", regRdData_ff, u_uart_host_model.expQ.pop_front());
        end
    end

    initial begin
        {rxHolding, lineStatus, modemStatus, txFifoFill, rxFifoFill, irqIdent} = '0;
        void'($urandom(17));
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        rxHolding <= 8'($urandom);
        lineStatus <= 8'($urandom);
        modemStatus <= 8'($urandom);
        txFifoFill <= 8'($urandom);
        rxFifoFill <= 8'($urandom);
        irqIdent <= 6'($urandom);
        s = 8'($urandom);
        tick();
        check("irqEnable reset", irqEnable_ff, REG_RST);
        wrReg(OFS_SPR, s);
        wrReg(OFS_LSR, ~s);
        wrReg(OFS_MSR, ~s);
        wrReg(OFS_TX_FIFO_FILL, ~s);
        wrReg(OFS_RX_FIFO_FILL, ~s);
        rdReg(OFS_SPR, s);
        rdReg(OFS_LSR, lineStatus);
        rdReg(OFS_MSR, modemStatus);
        rdReg(OFS_TX_FIFO_FILL, txFifoFill);
        rdReg(OFS_RX_FIFO_FILL, rxFifoFill);
        rdReg(OFS_RSVD, 8'h00);
        wrReg(OFS_IER, 8'hff);
        wrReg(OFS_MCR, 8'hf6);
        wrReg(OFS_FCR, 8'hf1);
        tick();
        check("irqEnable locked", irqEnable_ff, IER_BASE_MASK);
        check("modemControl locked", modemControl_ff, 8'h12);
        check("fifoControl locked", fifoControl_ff, FCR_BASE_MASK);
        wrReg(OFS_LCR, 8'h80);
        wrReg(OFS_DLL, 8'h0c);
        wrReg(OFS_DLH, 8'h00);
        wrReg(OFS_SPR, ~s);
        tick();
        tick();
        check("baudEnable on", {7'h0, baudEnable_ff}, 8'h01);
        rdReg(OFS_DLL, 8'h0c);
        rdReg(OFS_DLH, 8'h00);
        wrReg(OFS_DLL, 8'h00);
        tick();
        tick();
        check("baudEnable off", {7'h0, baudEnable_ff}, 8'h00);
        check("scratchpad hidden", scratchpad_ff, s);
        wrReg(OFS_LCR, LCR_ENH_KEY);
        e = {3'($urandom), 1'b1, 4'($urandom)};
        wrReg(OFS_EFR, e);
        for (int i = 4; i < 8; i++) wrReg(4'(i), 8'(i * 17) ^ s);
        tick();
        check("enhancedFeatures", enhancedFeatures_ff, e);
        for (int i = 4; i < 8; i++) rdReg(4'(i), 8'(i * 17) ^ s);
        check("modemControl kept", modemControl_ff, 8'h12);
        wrReg(OFS_LCR, 8'h03);
        wrReg(OFS_IER, 8'hff);
        wrReg(OFS_MCR, 8'hf6);
        wrReg(OFS_TCR, ~s);
        wrReg(OFS_TLR, s ^ 8'h5a);
        tick();
        check("irqEnable open", irqEnable_ff, 8'hff);
        check("modemControl open", modemControl_ff, 8'hf6);
        rdReg(OFS_TCR, ~s);
        rdReg(OFS_TLR, s ^ 8'h5a);
        check("scratchpad window", scratchpad_ff, s);
        wrReg(OFS_FCR, 8'hf7);
        #1;
        for (int k = 0; k < 3; k++) begin
            check("rxFifoReset", {7'h0, rxFifoReset_ff}, 8'(k < 2));
            check("txFifoReset", {7'h0, txFifoReset_ff}, 8'(k < 2));
            tick();
        end
        check("fifoControl", fifoControl_ff, 8'hf1);
        rdReg(OFS_HOLD, rxHolding);
        #1;
        check("rxPop", {7'h0, rxPop_ff}, 8'h01);
        for (int k = 0; k < 2; k++) begin
            rdReg(OFS_FCR, {2'b11, irqIdent});
            #1;
            check("irqIdentRead", {7'h0, irqIdentRead_ff}, 8'h01);
        end
        wrReg(OFS_HOLD, s);
        #1;
        check("txPush", {7'h0, txPush_ff}, 8'h01);
        check("txData", txData_ff, s);
        wrReg(OFS_SRST, 8'hff);
        #1;
        check("softReset", {7'h0, softReset_ff}, 8'h01);
        wrReg(OFS_EXTRA_FEATURES, 8'hff);
        tick();
        check("extraFeatures", extraFeatures_ff, 8'hb7);
        for (int k = 0; k < 10 && u_uart_host_model.expQ.size() != 0; k++) tick();
        if (u_uart_host_model.expQ.size() != 0) check("reads pending", 8'h00, 8'hff);
        close_out();
    end
endmodule
`default_nettype wire
